// *** logic/mcire_params.svh ***
/*
 Offsets, opcodes, status codes and reset values for the motion command
 interpreter slice. Assumes inclusion by bare name from logic/.
*/
`ifndef MCIRE_PARAMS_SVH
`define MCIRE_PARAMS_SVH

`define MCIRE_FRAME_BYTES 9
`define MCIRE_OP_DEFVECT 8'h25
`define MCIRE_OP_RETHND 8'h26
`define MCIRE_OP_USER_LO 8'h40
`define MCIRE_OP_USER_HI 8'h47
`define MCIRE_OP_MOVE 8'h04
`define MCIRE_OP_REACH 8'h8a
`define MCIRE_ST_OK 8'h64
`define MCIRE_ST_REACHED 8'h80
`define MCIRE_ST_BADSUM 8'h01
`define MCIRE_ST_BADCMD 8'h02
`define MCIRE_ST_BADTYPE 8'h03
`define MCIRE_HOST_ADDR 8'h02
`define MCIRE_MOD_ADDR 8'h01
`define MCIRE_REACH_ONCE 8'h00
`define MCIRE_REACH_ALL 8'h01
`define MCIRE_VEC_RESET 24'h000000

`endif

// *** logic/mcire_pkg.sv ***
/*
 Types for the motion command interpreter slice.
 Assumes nothing beyond the params header.
*/
`default_nettype none
package mcire_pkg;
    typedef logic [7:0] mcire_byte_t;
    typedef struct packed {
        mcire_byte_t addr;
        mcire_byte_t cmd;
        mcire_byte_t typ;
        mcire_byte_t bank;
        logic [31:0] value;
    } mcire_cmd_t;
    typedef enum {MCIRE_IDLE, MCIRE_SEND} mcire_tx_state_t;
endpackage
`default_nettype wire

// *** logic/mcire_frame_if.sv ***
/*
 Interface carrying one finished reply frame between interpreter and
 serialiser. Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mcire_frame_if;
    logic valid;
    logic ready;
    logic [63:0] body;
    modport src (output valid, output body, input ready);
    modport snk (input valid, input body, output ready);
endinterface
`default_nettype wire

// *** logic/mcire_reply_tx.sv ***
/*
 Reply serialiser: appends the modulo-256 checksum and sends nine bytes.
 Assumes the byte sink may stall with txReady low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcire_params.svh"
module mcire_reply_tx
    import mcire_pkg::*;
(
    input wire logic ref_clk,  // System clock
    input wire logic reset,    // Sync reset
    mcire_frame_if.snk frm,    // Frame to send
    output logic txValid,      // Byte valid
    output logic [7:0] txByte, // Byte out
    input wire logic txReady   // Sink takes byte
);
    mcire_tx_state_t state_q;
    logic [63:0] body_q;
    logic [7:0] sum_q;
    logic [3:0] idx_q;

    function automatic logic [7:0] sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction

    assign frm.ready = (state_q == MCIRE_IDLE);
    assign txValid = (state_q == MCIRE_SEND);
    assign txByte = (idx_q == 4'h8) ? sum_q : body_q[63:56];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= MCIRE_IDLE;
            body_q <= 64'h0;
            sum_q <= 8'h00;
            idx_q <= 4'h0;
        end else begin
            unique case (state_q)
                MCIRE_IDLE: begin
                    if (frm.valid) begin
                        body_q <= frm.body;
                        sum_q <= sum8(frm.body);
                        idx_q <= 4'h0;
                        state_q <= MCIRE_SEND;
                    end
                end
                MCIRE_SEND: begin
                    if (txReady) begin
                        body_q <= {body_q[55:0], 8'h00};
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == 4'h8) begin
                            state_q <= MCIRE_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** logic/mcire_interp.sv ***
/*
 Command interpreter slice: interrupt vectors, handler return, user
 extension opcodes and the position-reached event with its second reply.
 Assumes bytes arrive synchronous to ref_clk, and a motion engine that
 pulses targetReached; a stored-program core drives the irq/exec ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcire_params.svh"
module mcire_interp
    import mcire_pkg::*;
#(
    parameter int NUM_IRQ = 16,   // Interrupt vector count
    parameter int PC_W = 24,      // Program counter width
    parameter int FLAG_W = 8      // Flags width
) (
    input wire logic ref_clk,               // 100 MHz system clock
    input wire logic reset,                 // Sync reset, active high
    input wire logic rxValid,               // Host byte valid
    input wire logic [7:0] rxByte,          // Host byte
    output logic txValid,                   // Reply byte valid
    output logic [7:0] txByte,              // Reply byte
    input wire logic txReady,               // Reply byte taken
    input wire logic frameResync,           // Drop partial frame
    input wire logic progValid,             // Stored-program instruction
    input wire logic [7:0] progCmd,         // Its opcode
    input wire logic [7:0] progType,        // Its type field
    input wire logic [31:0] progValue,      // Its value field
    input wire logic irqFire,               // Enabled interrupt fires
    input wire logic [7:0] irqNum,          // Which interrupt
    input wire logic [31:0] curAccu,        // Live accumulator
    input wire logic [31:0] curX,           // Live X register
    input wire logic [FLAG_W-1:0] curFlags, // Live flags
    input wire logic [PC_W-1:0] curPc,      // Live program counter
    output logic ctxLoad,                   // Load restored/jump context
    output logic [31:0] loadAccu,           // Accumulator to load
    output logic [31:0] loadX,              // X to load
    output logic [FLAG_W-1:0] loadFlags,    // Flags to load
    output logic [PC_W-1:0] loadPc,         // Program counter to load
    output logic userCmd,                   // User extension pulse
    output logic [2:0] userFunc,            // Which extension
    input wire logic [31:0] userReply,      // User-defined reply value
    output logic moveIssued,                // Move command accepted
    input wire logic targetReached,         // Engine reached target
    output logic reachArmed                 // Reach event armed or move in flight
);
    // Refused at elaboration: the vector index is at most one byte wide
    if (NUM_IRQ < 1 || NUM_IRQ > 256 || PC_W < 1 || PC_W > 32 ||
        FLAG_W < 1 || FLAG_W > 32) begin : g_bad_params
        $error("mcire_interp: unsupported parameters");
    end

    localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

    mcire_frame_if frm ();

    logic [PC_W-1:0] vec_q [NUM_IRQ];
    logic [31:0] saveAccu_q, saveX_q;
    logic [FLAG_W-1:0] saveFlags_q;
    logic [PC_W-1:0] savePc_q;
    logic [63:0] rxBuf_q;
    logic [3:0] rxCnt_q;
    logic [7:0] rxSum_q;
    logic cmdStb_q;
    mcire_cmd_t cmd_q;
    logic cmdOk_q;
    logic armOnce_q, armAll_q, moving_q;
    logic [7:0] mask_q;
    logic pendReply_q, pendReach_q;
    logic [63:0] pendBody_q, reachBody_q;
    logic [7:0] rstatus;
    logic [31:0] rvalue;
    logic isUser;

    function automatic logic [63:0] reply_body(input logic [7:0] st,
            input logic [7:0] cmd, input logic [31:0] val);
        return {`MCIRE_HOST_ADDR, `MCIRE_MOD_ADDR, st, cmd, val};
    endfunction

    // Range is checked by callers; this only trims to the table index
    function automatic logic [IDX_W-1:0] vec_idx(input logic [7:0] n);
        return n[IDX_W-1:0];
    endfunction

    // Frame assembly; checksum is checked on the ninth byte
    always_ff @(posedge ref_clk) begin
        if (reset || frameResync) begin
            rxCnt_q <= 4'h0;
            rxSum_q <= 8'h00;
            rxBuf_q <= 64'h0;
            cmdStb_q <= 1'b0;
            cmdOk_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            cmdStb_q <= 1'b0;
            if (rxValid) begin
                if (rxCnt_q == 4'h8) begin
                    rxCnt_q <= 4'h0;
                    rxSum_q <= 8'h00;
                    cmdStb_q <= 1'b1;
                    cmdOk_q <= (rxByte == rxSum_q);
                    cmd_q <= mcire_cmd_t'(rxBuf_q);
                end else begin
                    rxCnt_q <= rxCnt_q + 4'h1;
                    rxSum_q <= rxSum_q + rxByte;
                    rxBuf_q <= {rxBuf_q[55:0], rxByte};
                end
            end
        end
    end

    assign isUser = cmd_q.cmd >= `MCIRE_OP_USER_LO &&
                    cmd_q.cmd <= `MCIRE_OP_USER_HI;

    always_comb begin
        rstatus = `MCIRE_ST_OK;
        rvalue = 32'h0;
        if (!cmdOk_q) begin
            rstatus = `MCIRE_ST_BADSUM;
        end else if (cmd_q.cmd == `MCIRE_OP_DEFVECT ||
                     cmd_q.cmd == `MCIRE_OP_RETHND) begin
            rstatus = `MCIRE_ST_OK;
        end else if (isUser) begin
            rvalue = userReply;
        end else if (cmd_q.cmd == `MCIRE_OP_REACH) begin
            if (cmd_q.typ > `MCIRE_REACH_ALL) begin
                rstatus = `MCIRE_ST_BADTYPE;
            end
            rvalue = {24'h0, cmd_q.value[7:0]};
        end else if (cmd_q.cmd != `MCIRE_OP_MOVE) begin
            rstatus = `MCIRE_ST_BADCMD;
        end
    end

    assign userCmd = cmdStb_q && cmdOk_q && isUser;
    assign userFunc = cmd_q.cmd[2:0];
    assign moveIssued = cmdStb_q && cmdOk_q && cmd_q.cmd == `MCIRE_OP_MOVE;
    assign reachArmed = armOnce_q || armAll_q || moving_q;

    // Vector table: direct or stored define-vector writes an entry
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                vec_q[i] <= PC_W'(`MCIRE_VEC_RESET);
            end
        end else if (cmdStb_q && cmdOk_q && cmd_q.cmd == `MCIRE_OP_DEFVECT &&
                     32'(cmd_q.typ) < NUM_IRQ) begin
            vec_q[vec_idx(cmd_q.typ)] <= cmd_q.value[PC_W-1:0];
        end else if (progValid && progCmd == `MCIRE_OP_DEFVECT &&
                     32'(progType) < NUM_IRQ) begin
            vec_q[vec_idx(progType)] <= progValue[PC_W-1:0];
        end
    end

    // Context save on interrupt entry
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            saveAccu_q <= 32'h0;
            saveX_q <= 32'h0;
            saveFlags_q <= '0;
            savePc_q <= '0;
        end else if (irqFire) begin
            saveAccu_q <= curAccu;
            saveX_q <= curX;
            saveFlags_q <= curFlags;
            savePc_q <= curPc;
        end
    end

    // Context load: jump to vector, or restore on return
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctxLoad <= 1'b0;
            loadAccu <= 32'h0;
            loadX <= 32'h0;
            loadFlags <= '0;
            loadPc <= '0;
        end else begin
            ctxLoad <= 1'b0;
            if (irqFire && 32'(irqNum) < NUM_IRQ) begin
                ctxLoad <= 1'b1;
                loadAccu <= curAccu;
                loadX <= curX;
                loadFlags <= curFlags;
                loadPc <= vec_q[vec_idx(irqNum)];
            end else if (progValid && progCmd == `MCIRE_OP_RETHND) begin
                ctxLoad <= 1'b1;
                loadAccu <= saveAccu_q;
                loadX <= saveX_q;
                loadFlags <= saveFlags_q;
                loadPc <= savePc_q;
            end
        end
    end

    // Reached-event arming; the request is only decoded from host frames
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            armOnce_q <= 1'b0;
            armAll_q <= 1'b0;
            moving_q <= 1'b0;
            mask_q <= 8'h00;
        end else begin
            if (cmdStb_q && cmdOk_q && cmd_q.cmd == `MCIRE_OP_REACH) begin
                mask_q <= cmd_q.value[7:0];
                armOnce_q <= cmd_q.typ == `MCIRE_REACH_ONCE;
                armAll_q <= cmd_q.typ == `MCIRE_REACH_ALL;
            end else if (moveIssued && armOnce_q) begin
                armOnce_q <= 1'b0;
            end
            // A new move beats a reach in the same cycle
            if (moveIssued && (armOnce_q || armAll_q)) begin
                moving_q <= 1'b1;
            end else if (targetReached) begin
                moving_q <= 1'b0;
            end
        end
    end

    // Reply queue: one immediate, one reached; immediate goes first
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pendReply_q <= 1'b0;
            pendReach_q <= 1'b0;
            pendBody_q <= 64'h0;
            reachBody_q <= 64'h0;
        end else begin
            if (cmdStb_q) begin
                pendReply_q <= 1'b1;
                pendBody_q <= reply_body(rstatus, cmd_q.cmd, rvalue);
            end else if (frm.ready && pendReply_q) begin
                pendReply_q <= 1'b0;
            end
            if (moving_q && targetReached && !moveIssued) begin
                pendReach_q <= 1'b1;
                reachBody_q <= reply_body(`MCIRE_ST_REACHED,
                    `MCIRE_OP_REACH, {24'h0, mask_q});
            end else if (frm.ready && !pendReply_q && pendReach_q) begin
                pendReach_q <= 1'b0;
            end
        end
    end

    assign frm.valid = pendReply_q || pendReach_q;
    assign frm.body = pendReply_q ? pendBody_q : reachBody_q;

    mcire_reply_tx u_tx (
        .ref_clk(ref_clk),
        .reset(reset),
        .frm(frm),
        .txValid(txValid),
        .txByte(txByte),
        .txReady(txReady)
    );
endmodule
`default_nettype wire

// *** tb/mcire_checker.sv ***
/*
 Port checker for the interpreter slice.
 Assumes binding to mcire_interp on the single ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mcire_checker (
    input wire logic ref_clk,        // Clock
    input wire logic reset,          // Sync reset
    input wire logic txValid,        // Reply byte valid
    input wire logic [7:0] txByte,   // Reply byte
    input wire logic txReady,        // Byte taken
    input wire logic progValid,      // Program op
    input wire logic [7:0] progCmd,  // Its opcode
    input wire logic irqFire,        // Interrupt fires
    input wire logic [7:0] irqNum,   // Its number
    input wire logic ctxLoad,        // Context load
    input wire logic userCmd,        // User op pulse
    input wire logic reachArmed      // Reach pending
);
    logic [3:0] idx_q;
    logic [7:0] sum_q;
    logic lastByte;
    assign lastByte = txValid && txReady && idx_q == 4'h8;
    // Position of the next offered byte within its reply frame
    always_ff @(posedge ref_clk) begin
        if (reset || lastByte) begin
            idx_q <= 4'h0;
        end else if (txValid && txReady) begin
            idx_q <= idx_q + 4'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset || lastByte) begin
            sum_q <= 8'h00;
        end else if (txValid && txReady) begin
            sum_q <= sum_q + txByte;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_reply_host_addr: assert property (
        txValid && idx_q == 4'h0 |-> txByte == 8'h02)
        else $error("reply host address byte wrong");
    chk_reply_mod_addr: assert property (
        txValid && idx_q == 4'h1 |-> txByte == 8'h01)
        else $error("reply module address byte wrong");
    chk_reply_sum: assert property (
        txValid && idx_q == 4'h8 |-> txByte == sum_q)
        else $error("reply checksum byte wrong");
    chk_byte_holds: assert property (
        txValid && !txReady |=> txValid && $stable(txByte))
        else $error("reply byte dropped while stalled");
    chk_return_loads: assert property (
        progValid && progCmd == 8'h26 |=> ctxLoad)
        else $error("handler return gave no context load");
    chk_irq_jumps: assert property (
        irqFire && irqNum < 8'h10 |=> ctxLoad)
        else $error("interrupt gave no jump");
    chk_load_cause: assert property (
        ctxLoad |-> $past(irqFire && irqNum < 8'h10 ||
            progValid && progCmd == 8'h26))
        else $error("context load without interrupt or return");
    chk_user_answers: assert property (
        userCmd && !txValid |-> ##2 txValid)
        else $error("user opcode reply late");
    chk_reset_clean: assert property (
        $fell(reset) |-> !txValid && !ctxLoad && !reachArmed)
        else $error("outputs busy after reset");
endmodule
bind mcire_interp mcire_checker chk (.ref_clk, .reset, .txValid, .txByte,
    .txReady, .progValid, .progCmd, .irqFire, .irqNum, .ctxLoad, .userCmd,
    .reachArmed);
`default_nettype wire

// *** tb/mcire_host_model.sv ***
/*
 Host side of the command link: sends checksummed frames, collects replies.
 Assumes one byte per cycle and bench tasks calling send.
*/
`timescale 1ns/1ps
`default_nettype none
module mcire_host_model (
    input wire logic ref_clk,       // Clock
    input wire logic txValid,       // Reply byte valid
    input wire logic [7:0] txByte,  // Reply byte
    output logic rxValid,           // Command byte valid
    output logic [7:0] rxByte,      // Command byte
    output logic txReady            // Reply byte taken
);
    logic slow = 1'b0;
    logic [7:0] rq[$];
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h5a;
        txReady = 1'b1;
    end
    // Stalling every other cycle exercises the byte hold
    always @(negedge ref_clk) txReady <= slow ? ~txReady : 1'b1;
    always @(posedge ref_clk) if (txValid && txReady) rq.push_back(txByte);
    task automatic send(input logic [7:0] c, t, input logic [31:0] v,
            input logic bad);
        logic [63:0] f;
        logic [7:0] s;
        f = {8'h01, c, t, 8'h00, v};
        s = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            @(negedge ref_clk);
            rxValid <= 1'b1;
            rxByte <= f[i*8 +: 8];
            s = s + f[i*8 +: 8];
        end
        @(negedge ref_clk);
        rxByte <= s ^ {7'h00, bad};
        @(negedge ref_clk);
        rxValid <= 1'b0;
        rxByte <= ~s;
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 Self-checking bench for the interpreter slice.
 Assumes the host model on the link and program/engine pins driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic rxValid, txValid, txReady, progValid, irqFire, ctxLoad, userCmd;
    logic moveIssued, targetReached, reachArmed;
    logic [7:0] rxByte, txByte, progCmd, progType, irqNum, curFlags;
    logic [7:0] loadFlags;
    logic [2:0] userFunc, lastFunc;
    logic [31:0] progValue, curAccu, curX, loadAccu, loadX, userReply;
    logic [23:0] curPc, loadPc;
    logic [71:0] f;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int moves = 0;
    mcire_interp dut (.ref_clk, .reset, .rxValid, .rxByte, .txValid, .txByte,
        .txReady, .frameResync(1'b0), .progValid, .progCmd, .progType,
        .progValue, .irqFire, .irqNum, .curAccu, .curX, .curFlags, .curPc,
        .ctxLoad, .loadAccu, .loadX, .loadFlags, .loadPc, .userCmd,
        .userFunc, .userReply, .moveIssued, .targetReached, .reachArmed);
    mcire_host_model host (.ref_clk, .txValid, .txByte, .rxValid, .rxByte,
        .txReady);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (userCmd) lastFunc <= userFunc;
    always @(posedge ref_clk) if (moveIssued) moves++;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic [71:0] mk(input logic [7:0] st, c,
            input logic [31:0] v);
        logic [63:0] b;
        logic [7:0] s;
        b = {8'h02, 8'h01, st, c, v};
        s = 8'h00;
        for (int i = 0; i < 8; i++) s = s + b[i*8 +: 8];
        return {b, s};
    endfunction
    task automatic cmp(input logic [71:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic take(output logic [71:0] r);
        int n;
        n = 0;
        r = 'x;
        while (host.rq.size() < 9 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (host.rq.size() >= 9) begin
            for (int i = 0; i < 9; i++) r = {r[63:0], host.rq.pop_front()};
        end
    endtask
    task automatic expect_reply(input logic [7:0] st, c,
            input logic [31:0] v, input logic useVal);
        logic [71:0] e;
        take(f);
        e = mk(st, c, v);
        // Value and its checksum ignored where the reply value is free
        if (!useVal) begin
            f[39:0] = '0;
            e[39:0] = '0;
        end
        cmp(f, e);
    endtask
    task automatic quiet();
        repeat (40) @(negedge ref_clk);
        cmp(72'(host.rq.size()), 72'h0);
    endtask
    task automatic prog(input logic [7:0] c, t, input logic [31:0] v);
        @(negedge ref_clk);
        {progValid, progCmd, progType, progValue} = {1'b1, c, t, v};
        @(negedge ref_clk);
        progValid = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic irq(input logic [7:0] n);
        @(negedge ref_clk);
        {irqFire, irqNum} = {1'b1, n};
        @(negedge ref_clk);
        irqFire = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic move_and_reach(input logic replyDue);
        int m0;
        m0 = moves;
        host.send(8'h04, 8'h00, 32'h0000_0100, 1'b0);
        expect_reply(8'h64, 8'h04, 32'h0, 1'b0);
        cmp(72'(moves - m0), 72'h1);
        @(negedge ref_clk);
        targetReached = 1'b1;
        @(negedge ref_clk);
        targetReached = 1'b0;
        if (replyDue) expect_reply(8'h80, 8'h8a, 32'h1, 1'b1);
        else quiet();
    endtask
    task automatic s_vectors;
        {curAccu, curX, curFlags, curPc} = {32'ha5a5, 32'h11, 8'h3c, 24'h10};
        prog(8'h25, 8'h03, 32'h123);
        irq(8'h03);
        cmp(72'(loadPc), 72'h123);
        host.send(8'h25, 8'h03, 32'h456, 1'b0);
        expect_reply(8'h64, 8'h25, 32'h0, 1'b0);
        irq(8'h03);
        cmp(72'(loadPc), 72'h456);
        {curAccu, curX, curFlags, curPc} = {32'h0, 32'h0, 8'h0, 24'h77};
        prog(8'h26, 8'h00, 32'h0);
        cmp({loadX[7:0], loadFlags, loadPc, loadAccu},
            {8'h11, 8'h3c, 24'h10, 32'ha5a5});
        host.send(8'h26, 8'hff, 32'h0, 1'b0);
        expect_reply(8'h64, 8'h26, 32'h0, 1'b0);
        host.send(8'h25, 8'h03, 32'h999, 1'b1);
        expect_reply(8'h01, 8'h25, 32'h0, 1'b0);
        irq(8'h03);
        cmp(72'(loadPc), 72'h456);
    endtask
    task automatic s_user;
        for (int k = 0; k < 8; k++) begin
            userReply = 32'h00ab_0000 + 32'(k);
            host.send(8'h40 + 8'(k), 8'h07, 32'h1234, 1'b0);
            expect_reply(8'h64, 8'h40 + 8'(k), userReply, 1'b1);
            cmp(72'(lastFunc), 72'(k));
        end
    endtask
    task automatic s_reach;
        host.send(8'h8a, 8'h00, 32'h1, 1'b0);
        expect_reply(8'h64, 8'h8a, 32'h1, 1'b1);
        move_and_reach(1'b1);
        move_and_reach(1'b0);
        cmp(72'(reachArmed), 72'h0);
        prog(8'h8a, 8'h01, 32'h1);
        cmp(72'(reachArmed), 72'h0);
        host.send(8'h8a, 8'h02, 32'h1, 1'b0);
        expect_reply(8'h03, 8'h8a, 32'h0, 1'b0);
        move_and_reach(1'b0);
        host.slow = 1'b1;
        host.send(8'h8a, 8'h01, 32'h1, 1'b0);
        expect_reply(8'h64, 8'h8a, 32'h1, 1'b1);
        for (int k = 0; k < 3; k++) move_and_reach(1'b1);
        host.slow = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {progValid, progCmd, progType, progValue} = '0;
        {irqFire, irqNum, targetReached, userReply} = '0;
        {curAccu, curX, curFlags, curPc} = '0;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        s_vectors();
        s_user();
        s_reach();
        wrap_up();
    end
endmodule
`default_nettype wire
